/* rcs_map.svh */
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// ==========================================================================
// Address map
// ==========================================================================
// Printed offsets are register indices; the byte address is four times the index.
`define RCS_ADDR_W 12
`define RCS_IDX_W 10
`define RCS_FLAGS_IDX 10'h08e
`define RCS_CFG_IDX 10'h08f

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define RCS_POR_BIT 1
`define RCS_BOR_BIT 0
`define RCS_CFG_BOD_BIT 0
`define RCS_POR_RST 1'b0
`define RCS_BOR_RST 1'b1
`define RCS_CFG_BOD_RST 1'b1

// ==========================================================================
// Bus answers
// ==========================================================================
`define RCS_RESP_OKAY 2'b00
`define RCS_RESP_SLVERR 2'b10

`endif

/* rcs_pkg.sv */
`include "rcs_map.svh"

package rcs_pkg;

  // ==========================================================================
  // State of the bus slave and register file
  // ==========================================================================
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic [`RCS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic flag_we;
    logic [1:0] flag_wd;
    logic bod_en;
  } rcs_slave_st_t;

  // ==========================================================================
  // State of one flag cell
  // ==========================================================================
  typedef struct packed {
    logic flag;
  } rcs_cell_st_t;

endpackage : rcs_pkg

/* rcs_cause_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Reset events in, per-flag clear requests out.
interface rcs_cause_if;
  logic por_event;
  logic bor_event;
  logic watchdog_reset;
  logic external_reset_pin;
  logic brownout_detect_enable;
  logic clr_por;
  logic clr_bor;

  modport decoder (
    input por_event,
    input bor_event,
    input watchdog_reset,
    input external_reset_pin,
    input brownout_detect_enable,
    output clr_por,
    output clr_bor
  );

  modport owner (
    output por_event,
    output bor_event,
    output watchdog_reset,
    output external_reset_pin,
    output brownout_detect_enable,
    input clr_por,
    input clr_bor
  );
endinterface : rcs_cause_if

`default_nettype wire

/* rcs_cause_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module rcs_cause_decode (
  // Events and clear requests
  rcs_cause_if.decoder cif
);
  import rcs_pkg::*;

  // ==========================================================================
  // Cause decode
  // ==========================================================================
  // A power-on event clears only the power-on flag, a brown-out event only the
  // brown-out flag, and the watchdog and pin resets touch neither, so those two
  // sources leave the same trace in the two flags.
  assign cif.clr_por = cif.por_event;
  // With the detector disabled the brown-out flag is left alone.
  assign cif.clr_bor = cif.bor_event & cif.brownout_detect_enable;
  // Watchdog and external pin resets are deliberately not decoded.

endmodule : rcs_cause_decode

`default_nettype wire

/* rcs_flag_cell.sv */
`timescale 1ns/100ps
`default_nettype none

module rcs_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Software write
  input wire logic wr_en,
  input wire logic wr_val,
  // Hardware clear
  input wire logic hw_clr,
  // Flag value
  output logic flag_q
);
  import rcs_pkg::*;

  rcs_cell_st_t st_reg;
  rcs_cell_st_t st_next;

  // ==========================================================================
  // Flag update
  // ==========================================================================
  // The hardware clear beats a software write in the same cycle, so an event
  // that lands while firmware rearms the flag is never lost.
  always_comb begin
    st_next = st_reg;
    if (hw_clr) begin
      st_next.flag = 1'b0;
    end else if (wr_en) begin
      st_next.flag = wr_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{flag: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag_q = st_reg.flag;

endmodule : rcs_flag_cell

`default_nettype wire

/* rcs_top.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_map.svh"

module rcs_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`RCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`RCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset event inputs
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic watchdog_reset,
  input wire logic external_reset_pin,
  // Status
  output logic [7:0] reset_cause_flags,
  output logic brownout_detect_enable
);
  import rcs_pkg::*;

  rcs_slave_st_t s_reg;
  rcs_slave_st_t s_next;
  logic por_q;
  logic bor_q;
  logic [1:0] flags_now;
  logic [`RCS_IDX_W-1:0] aw_idx;
  logic [`RCS_IDX_W-1:0] ar_idx;

  rcs_cause_if cif ();

  // ==========================================================================
  // Cause decode and flag storage
  // ==========================================================================
  assign cif.por_event = por_event;
  assign cif.bor_event = bor_event;
  assign cif.watchdog_reset = watchdog_reset;
  assign cif.external_reset_pin = external_reset_pin;
  assign cif.brownout_detect_enable = s_reg.bod_en;

  rcs_cause_decode u_decode (
    .cif(cif.decoder)
  );

  rcs_flag_cell #(
    .RST_VAL(`RCS_POR_RST)
  ) u_por_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(s_reg.flag_we),
    .wr_val(s_reg.flag_wd[`RCS_POR_BIT]),
    .hw_clr(cif.clr_por),
    .flag_q(por_q)
  );

  rcs_flag_cell #(
    .RST_VAL(`RCS_BOR_RST)
  ) u_bor_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(s_reg.flag_we),
    .wr_val(s_reg.flag_wd[`RCS_BOR_BIT]),
    .hw_clr(cif.clr_bor),
    .flag_q(bor_q)
  );

  assign flags_now = {por_q, bor_q};
  assign aw_idx = s_reg.aw_addr[`RCS_ADDR_W-1:2];
  assign ar_idx = s_axi_araddr[`RCS_ADDR_W-1:2];

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  // Only one write and one read are in flight; the ready lines drop while an
  // answer waits, which keeps the slave free of any response queue.
  always_comb begin
    s_next = s_reg;
    s_next.flag_we = 1'b0;
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      if (aw_idx == `RCS_FLAGS_IDX) begin
        s_next.bresp = `RCS_RESP_OKAY;
        s_next.flag_we = s_reg.w_lane0;
        // Upper data bits are dropped here and have no storage.
        s_next.flag_wd = s_reg.w_data[1:0];
      end else if (aw_idx == `RCS_CFG_IDX) begin
        s_next.bresp = `RCS_RESP_OKAY;
        if (s_reg.w_lane0) begin
          s_next.bod_en = s_reg.w_data[`RCS_CFG_BOD_BIT];
        end
      end else begin
        s_next.bresp = `RCS_RESP_SLVERR;
      end
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (ar_idx == `RCS_FLAGS_IDX) begin
        s_next.rresp = `RCS_RESP_OKAY;
        s_next.rdata[1:0] = flags_now;
      end else if (ar_idx == `RCS_CFG_IDX) begin
        s_next.rresp = `RCS_RESP_OKAY;
        s_next.rdata[`RCS_CFG_BOD_BIT] = s_reg.bod_en;
      end else begin
        s_next.rresp = `RCS_RESP_SLVERR;
      end
    end
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '{
        awready: 1'b0,
        wready: 1'b0,
        aw_got: 1'b0,
        aw_addr: '0,
        w_got: 1'b0,
        w_data: 8'h00,
        w_lane0: 1'b0,
        bvalid: 1'b0,
        bresp: `RCS_RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: `RCS_RESP_OKAY,
        flag_we: 1'b0,
        flag_wd: 2'h0,
        bod_en: `RCS_CFG_BOD_RST
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  // Unimplemented positions are constant zero, never storage.
  assign reset_cause_flags = {6'h00, por_q, bor_q};
  assign brownout_detect_enable = s_reg.bod_en;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_aw_single_take: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready
  ) else $error("write address ready did not drop after a take");

  chk_write_answer: assert property (
    s_reg.aw_got && s_reg.w_got && !s_reg.bvalid |=> s_axi_bvalid
  ) else $error("write response missing one cycle after commit");

  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before it was taken");

  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data changed before it was taken");

  chk_flags_read: assert property (
    s_axi_arvalid && s_axi_arready && ar_idx == `RCS_FLAGS_IDX
      |=> s_axi_rvalid && s_axi_rdata[1:0] == $past(flags_now) && s_axi_rresp == `RCS_RESP_OKAY
  ) else $error("flag read returned wrong value");

  chk_high_bits_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:2] == 30'h0 && reset_cause_flags[7:2] == 6'h00
  ) else $error("unimplemented bits not zero");

  chk_read_upper_zero: assert property (
    s_axi_arvalid && s_axi_arready && ar_idx == `RCS_FLAGS_IDX |=> s_axi_rdata[31:2] == 30'h0
  ) else $error("flag read shows bits above one");

  chk_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && ar_idx != `RCS_FLAGS_IDX && ar_idx != `RCS_CFG_IDX
      |=> s_axi_rresp == `RCS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000
  ) else $error("unmapped read not refused");

  chk_por_clear: assert property (
    por_event |=> !por_q [*1] ##0 reset_cause_flags[`RCS_POR_BIT] == 1'b0
  ) else $error("power-on event did not clear its flag");

  chk_por_rearm: assert property (
    s_reg.flag_we && s_reg.flag_wd[`RCS_POR_BIT] && !por_event |=> por_q
  ) else $error("software could not rearm power-on flag");

  chk_bor_clear: assert property (
    bor_event && s_reg.bod_en |=> !bor_q
  ) else $error("brown-out event did not clear its flag");

  chk_por_keeps_bor: assert property (
    por_event && !bor_event && !s_reg.flag_we |=> $stable(bor_q)
  ) else $error("power-on event disturbed brown-out flag");

  chk_bor_disabled: assert property (
    bor_event && !s_reg.bod_en && !s_reg.flag_we |=> $stable(bor_q)
  ) else $error("brown-out event acted while detection disabled");

  chk_other_resets: assert property (
    (watchdog_reset || external_reset_pin) && !por_event && !bor_event && !s_reg.flag_we
      |=> $stable(flags_now)
  ) else $error("watchdog or pin reset changed the flags");

  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready
  ) else $error("read answer missing one cycle after take");

  chk_bor_rearm: assert property (
    s_reg.flag_we && s_reg.flag_wd[`RCS_BOR_BIT] && !(bor_event && s_reg.bod_en) |=> bor_q
  ) else $error("software could not rearm brown-out flag");

  // A refused or strobe-less write must never reach the flag cells.
  chk_write_refused: assert property (
    s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && (aw_idx != `RCS_FLAGS_IDX || !s_reg.w_lane0)
      |=> !s_reg.flag_we
  ) else $error("ignored write reached the flags");

  chk_unmapped_wresp: assert property (
    s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && aw_idx != `RCS_FLAGS_IDX && aw_idx != `RCS_CFG_IDX
      |=> s_axi_bresp == `RCS_RESP_SLVERR
  ) else $error("unmapped write not refused");

  chk_cfg_write: assert property (
    s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && aw_idx == `RCS_CFG_IDX && s_reg.w_lane0
      |=> brownout_detect_enable == $past(s_reg.w_data[`RCS_CFG_BOD_BIT])
  ) else $error("detector enable write did not land");

  cov_flag_write: cover property (
    s_reg.flag_we ##1 s_axi_bvalid && s_axi_bready
  );
  cov_flag_read: cover property (
    s_axi_arvalid && s_axi_arready && ar_idx == `RCS_FLAGS_IDX ##1 s_axi_rvalid
  );
  cov_por_then_rearm: cover property (
    por_event ##[1:50] s_reg.flag_we && s_reg.flag_wd[`RCS_POR_BIT]
  );
  cov_bor_seen: cover property (
    bor_event && s_reg.bod_en ##1 !bor_q
  );
  cov_bor_disabled: cover property (
    bor_event && !s_reg.bod_en ##1 bor_q
  );

endmodule : rcs_top

`default_nettype wire

/* reset_cause_status_register_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rcs_map.svh"

module reset_cause_status_register_test;
  // ==========================================================================
  // Clock, reset and ports
  // ==========================================================================
  localparam logic [11:0] FLAGS_A = {`RCS_FLAGS_IDX, 2'b00};
  localparam logic [11:0] CFG_A = {`RCS_CFG_IDX, 2'b00};
  localparam logic [11:0] HOLE_A = {10'h090, 2'b00};
  localparam logic [1:0] OK = `RCS_RESP_OKAY;
  localparam logic [1:0] ERR = `RCS_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bod_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] flags;
  logic [3:0] ev = '0;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 aclk = ~aclk;

  rcs_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .por_event(ev[3]), .bor_event(ev[2]), .watchdog_reset(ev[1]), .external_reset_pin(ev[0]),
    .reset_cause_flags(flags), .brownout_detect_enable(bod_en)
  );

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A hung handshake is ended here rather than by a wait count in each task.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  // Handshakes are judged at the falling edge, where inputs and registered
  // outputs are settled, and acted on at the next rising edge.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    logic aw_left;
    logic w_left;
    logic aw_t;
    logic w_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(negedge aclk);
      aw_t = aw_left && (awready === 1'b1);
      w_t = w_left && (wready === 1'b1);
      @(posedge aclk);
      if (aw_t) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_read

  // Two event cycles back to back, then quiet.
  task automatic pulse(input logic [3:0] v1, input logic [3:0] v2);
    @(posedge aclk);
    ev <= v1;
    @(posedge aclk);
    ev <= v2;
    @(posedge aclk);
    ev <= 4'h0;
    @(negedge aclk);
  endtask : pulse

  task automatic flags_are(input logic [7:0] exp);
    @(negedge aclk);
    check("flags out", {24'h0, flags}, {24'h0, exp});
    axi_read(FLAGS_A, {24'h0, exp}, OK);
  endtask : flags_are

  // ==========================================================================
  // Tests
  // ==========================================================================
  logic [3:0] ev1 [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hc, 4'h8};
  logic [3:0] ev2 [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4};
  logic [7:0] ev_exp [6] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h00, 8'h00};

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    flags_are(8'h01);
    check("bod enable", {31'h0, bod_en}, 32'h1);
    axi_read(CFG_A, 32'h1, OK);
    $display("test reset values done");

    axi_write(FLAGS_A, 32'hffff_ffff, 4'hf, OK);
    flags_are(8'h03);
    axi_write(FLAGS_A, 32'h0, 4'h1, OK);
    flags_are(8'h00);
    axi_write(FLAGS_A, 32'h3, 4'he, OK);
    flags_are(8'h00);
    $display("test register access done");

    for (int i = 0; i < 6; i++) begin
      axi_write(FLAGS_A, 32'h3, 4'h1, OK);
      flags_are(8'h03);
      pulse(ev1[i], ev2[i]);
      check("flags after event", {24'h0, flags}, {24'h0, ev_exp[i]});
      flags_are(ev_exp[i]);
    end
    $display("test reset events done");

    axi_write(FLAGS_A, 32'h3, 4'h1, OK);
    axi_write(CFG_A, 32'h0, 4'h1, OK);
    axi_read(CFG_A, 32'h0, OK);
    check("bod enable", {31'h0, bod_en}, 32'h0);
    pulse(4'h4, 4'h0);
    flags_are(8'h03);
    pulse(4'h8, 4'h0);
    flags_are(8'h01);
    axi_write(CFG_A, 32'h1, 4'h1, OK);
    $display("test detector disabled done");

    axi_write(HOLE_A, 32'hffff_ffff, 4'hf, ERR);
    axi_read(HOLE_A, 32'h0, ERR);
    flags_are(8'h01);
    $display("test unmapped done");

    axi_write(FLAGS_A, 32'h0, 4'h1, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    flags_are(8'h01);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : reset_cause_status_register_test

`default_nettype wire
